// ==== design/mms_serial_channel.v ====
// Multi-mode serial channel with AHB-Lite register slave
//
// Overview of operation
// RULE_01 - Falling edge starts frame; optional receive inversion
// RULE_02 - Mode field selects clocked, async or two-wire; the two-wire value leaves the channel idle
// RULE_03 - Interrupt source: transfer end or buffer empty
// RULE_04 - Transmit and receive enables set direction
// RULE_05 - Phase and polarity pick clocked timing type
// RULE_06 - Error enable gates error, masks done
// RULE_07 - Software keeps error enable zero when clocked
// RULE_08 - Transmit parity: none, zero, even, odd
// RULE_09 - Receive parity: none, unchecked, even, odd
// RULE_10 - Software clears parity bits when clocked
// RULE_11 - Bit order: MSB first or LSB first
// RULE_12 - Stop bit setting: none or one bit
// RULE_13 - Software clears stop bit when clocked
// RULE_14 - Data length seven or eight bits
// RULE_15 - Divider field sets transfer clock rate
// RULE_16 - Low data bits are transmit/receive buffer
// RULE_17 - Stop trigger clears active flag, halts
// RULE_18 - Software stops only when finishing communication
// RULE_19 - Software switches interrupt source during operation
// RULE_20 - Start source: software or receive edge
// RULE_21 - Start trigger sets active flag, waits
// RULE_22 - Operation clock from first or second prescaler
// RULE_23 - Parity failure flags error via error path
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "mms_defs.vh"
module mms_serial_channel (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Prescaler enables
  input wire prs0_tick_i,
  input wire prs1_tick_i,
  // Serial pins
  input wire rx_pin_i,
  output wire txd_o,
  output wire sck_o,
  // Events and state
  output wire xfer_irq_o,
  output wire rx_done_irq_o,
  output wire rx_error_irq_o,
  output wire channel_active_o
);
  localparam [2:0] T_IDLE = 3'd0;
  localparam [2:0] T_START = 3'd1;
  localparam [2:0] T_DATA = 3'd2;
  localparam [2:0] T_PAR = 3'd3;
  localparam [2:0] T_STOP = 3'd4;
  localparam [2:0] T_DONE = 3'd5;
  localparam [2:0] R_IDLE = 3'd0;
  localparam [2:0] R_START = 3'd1;
  localparam [2:0] R_DATA = 3'd2;
  localparam [2:0] R_PAR = 3'd3;
  localparam [2:0] R_STOP = 3'd4;
  localparam [2:0] R_DONE = 3'd5;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function [2:0] bit_idx;
    input lsb_first;
    input len8;
    input [2:0] cnt;
    begin
      if (lsb_first) begin // RULE_11
        bit_idx = cnt;
      end else begin
        bit_idx = (len8 ? 3'd7 : 3'd6) - cnt;
      end
    end
  endfunction

  function par_bit;
    input [1:0] ptc;
    input len8;
    input [7:0] d;
    reg p;
    begin
      p = ^{d[7] & len8, d[6:0]};
      case (ptc)
        `MMS_PTC_EVEN: par_bit = p;
        `MMS_PTC_ODD: par_bit = ~p;
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] mode_ff;
  reg [15:0] setup_ff;
  reg [6:0] div_ff;
  reg [7:0] tx_buf_ff;
  reg [7:0] rx_buf_ff;
  reg active_ff;
  reg tx_pend_ff;
  reg perr_ff;
  reg ferr_ff;
  reg wr_pend_ff;
  reg [19:0] wr_idx_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;
  reg [2:0] tx_st_ff;
  reg tx_half_ff;
  reg [2:0] tx_cnt_ff;
  reg [7:0] tx_sh_ff;
  reg txd_ff;
  reg sck_ff;
  reg xfer_irq_ff;
  reg [2:0] rx_st_ff;
  reg rx_half_ff;
  reg [2:0] rx_cnt_ff;
  reg [7:0] rx_sh_ff;
  reg rx_prev_ff;
  reg perr_frame_ff;
  reg ferr_frame_ff;
  reg rx_done_ff;
  reg rx_err_ff;
  reg [15:0] rd_val;

  wire tx_tick;
  wire rx_tick;
  wire [1:0] mode_sel = {mode_ff[`MMS_MODE_MDHI], mode_ff[`MMS_MODE_MDLO]};
  wire is_csi = (mode_sel == `MMS_MD_CSI); // RULE_02
  wire is_uart = (mode_sel == `MMS_MD_UART); // RULE_02
  wire run = active_ff & (is_csi | is_uart);
  wire tx_en = setup_ff[`MMS_SET_TXEN];
  wire rx_en = setup_ff[`MMS_SET_RXEN];
  wire dap = setup_ff[`MMS_SET_DAP];
  wire ckp = setup_ff[`MMS_SET_CKP];
  wire [1:0] ptc = {setup_ff[`MMS_SET_PTCHI], setup_ff[`MMS_SET_PTCLO]};
  wire lsb_first = setup_ff[`MMS_SET_DIR];
  wire stop_en = setup_ff[`MMS_SET_SLC];
  wire len8 = setup_ff[`MMS_SET_DLS];
  wire [2:0] last_cnt = len8 ? 3'd7 : 3'd6; // RULE_14
  wire irq_src = mode_ff[`MMS_MODE_IRQSRC];
  wire sw_start = ~mode_ff[`MMS_MODE_STSRC];
  wire op_tick = mode_ff[`MMS_MODE_OPCLK] ? prs1_tick_i : prs0_tick_i; // RULE_22
  wire rx_bit = rx_pin_i ^ mode_ff[`MMS_MODE_RXINV]; // RULE_01
  wire par_bad = ptc[1] & (rx_bit != par_bit(ptc, len8, rx_sh_ff)); // RULE_09 RULE_23
  wire [7:0] rx_masked = {rx_sh_ff[7] & len8, rx_sh_ff[6:0]};
  wire tx_dir_ok = is_uart ? tx_en : (tx_en | rx_en); // RULE_04
  wire tx_load = (tx_st_ff == T_IDLE) & run & tx_pend_ff & sw_start & tx_dir_ok; // RULE_20
  wire csi_sample = is_csi & (tx_st_ff == T_DATA) & tx_tick & (dap ? tx_half_ff : ~tx_half_ff); // RULE_05

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hreadyout_ff;
  assign hresp_o = hresp_ff;
  assign txd_o = txd_ff;
  assign sck_o = sck_ff;
  assign xfer_irq_o = xfer_irq_ff;
  assign rx_done_irq_o = rx_done_ff;
  assign rx_error_irq_o = rx_err_ff;
  assign channel_active_o = active_ff;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  wire addr_ok = (haddr_i[31:22] == 10'h000) & (haddr_i[1:0] == 2'b00);
  wire ahb_take = hsel_i & htrans_i[1] & hready_i;
  wire wr_mode = wr_pend_ff & (wr_idx_ff == `MMS_IDX_MODE);
  wire wr_setup = wr_pend_ff & (wr_idx_ff == `MMS_IDX_SETUP);
  wire wr_start = wr_pend_ff & (wr_idx_ff == `MMS_IDX_START);
  wire wr_stop = wr_pend_ff & (wr_idx_ff == `MMS_IDX_STOP);
  wire wr_data = wr_pend_ff & (wr_idx_ff == `MMS_IDX_DATA);
  wire wr_status = wr_pend_ff & (wr_idx_ff == `MMS_IDX_STATUS);

  always @* begin
    rd_val = 16'h0000;
    if (addr_ok) begin
      case (haddr_i[21:2])
        `MMS_IDX_MODE: rd_val = mode_ff;
        `MMS_IDX_SETUP: rd_val = setup_ff;
        `MMS_IDX_DATA: rd_val = {div_ff, 1'b0, rx_buf_ff}; // RULE_16
        `MMS_IDX_STATUS: rd_val = {10'h000, ferr_ff, perr_ff, (rx_st_ff != R_IDLE),
                                   (tx_st_ff != T_IDLE), tx_pend_ff, active_ff};
        default: rd_val = 16'h0000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 20'h0_0000;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      hresp_ff <= `MMS_HRESP_OKAY;
      mode_ff <= `MMS_RST_MODE;
      setup_ff <= `MMS_RST_SETUP;
      div_ff <= 7'h00;
      tx_buf_ff <= 8'h00;
      active_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= `MMS_HRESP_OKAY;
      wr_pend_ff <= ahb_take & hwrite_i & addr_ok;
      wr_idx_ff <= haddr_i[21:2];
      hrdata_ff <= (ahb_take & ~hwrite_i) ? {16'h0000, rd_val} : 32'h0000_0000;
      if (wr_mode) begin
        mode_ff <= (hwdata_i[15:0] & `MMS_WMASK_MODE) | `MMS_FIXED_MODE; // RULE_19
      end
      if (wr_setup) begin
        setup_ff <= (hwdata_i[15:0] & `MMS_WMASK_SETUP) | `MMS_FIXED_SETUP;
      end
      if (wr_data) begin
        div_ff <= hwdata_i[`MMS_DIV_HI:`MMS_DIV_LO]; // RULE_15
        tx_buf_ff <= hwdata_i[7:0]; // RULE_16
      end
      if (wr_start & hwdata_i[`MMS_TRIG_BIT]) begin
        active_ff <= 1'b1; // RULE_21
      end else if (wr_stop & hwdata_i[`MMS_TRIG_BIT]) begin
        active_ff <= 1'b0; // RULE_17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer clock dividers
  mms_tclk_div u_tx_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .op_tick_i(op_tick),
    .clr_i(tx_st_ff == T_IDLE),
    .div_i(div_ff),
    .half_tick_o(tx_tick)
  );

  mms_tclk_div u_rx_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .op_tick_i(op_tick),
    .clr_i(rx_st_ff == R_IDLE),
    .div_i(div_ff),
    .half_tick_o(rx_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmitter and clocked-mode engine
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_st_ff <= T_IDLE;
      tx_half_ff <= 1'b0;
      tx_cnt_ff <= 3'd0;
      tx_sh_ff <= 8'h00;
      tx_pend_ff <= 1'b0;
      txd_ff <= 1'b1;
      sck_ff <= 1'b1;
      xfer_irq_ff <= 1'b0;
    end else begin
      xfer_irq_ff <= 1'b0;
      if (tx_load) begin
        tx_pend_ff <= 1'b0;
        tx_sh_ff <= tx_buf_ff;
        tx_half_ff <= 1'b0;
        tx_cnt_ff <= 3'd0;
        tx_st_ff <= is_csi ? T_DATA : T_START;
        xfer_irq_ff <= irq_src; // RULE_03
      end else if (!run) begin
        tx_st_ff <= T_IDLE; // RULE_17
      end else if (tx_st_ff == T_DONE) begin
        tx_st_ff <= T_IDLE;
        xfer_irq_ff <= ~irq_src; // RULE_03
      end else if (tx_tick) begin
        tx_half_ff <= ~tx_half_ff;
        if (tx_half_ff) begin
          case (tx_st_ff)
            T_START: tx_st_ff <= T_DATA;
            T_DATA: begin
              if (tx_cnt_ff != last_cnt) begin
                tx_cnt_ff <= tx_cnt_ff + 3'd1;
              end else if (is_csi) begin
                tx_st_ff <= T_DONE;
              end else if (ptc != `MMS_PTC_NONE) begin
                tx_st_ff <= T_PAR; // RULE_08
              end else begin
                tx_st_ff <= stop_en ? T_STOP : T_DONE; // RULE_12
              end
            end
            T_PAR: tx_st_ff <= stop_en ? T_STOP : T_DONE; // RULE_12
            T_STOP: tx_st_ff <= T_DONE;
            default: tx_st_ff <= T_IDLE;
          endcase
        end
      end
      if (wr_data) begin
        tx_pend_ff <= 1'b1;
      end
      // Line levels follow the current state
      case (tx_st_ff)
        T_START: txd_ff <= 1'b0;
        T_DATA: txd_ff <= tx_en ? tx_sh_ff[bit_idx(lsb_first, len8, tx_cnt_ff)] : 1'b1; // RULE_11
        T_PAR: txd_ff <= par_bit(ptc, len8, tx_sh_ff); // RULE_08
        default: txd_ff <= 1'b1;
      endcase
      if (is_csi && tx_st_ff == T_DATA) begin
        sck_ff <= (dap ? tx_half_ff : ~tx_half_ff) ? ckp : ~ckp; // RULE_05
      end else begin
        sck_ff <= ~ckp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_st_ff <= R_IDLE;
      rx_half_ff <= 1'b0;
      rx_cnt_ff <= 3'd0;
      rx_sh_ff <= 8'h00;
      rx_buf_ff <= 8'h00;
      rx_prev_ff <= 1'b1;
      perr_frame_ff <= 1'b0;
      ferr_frame_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_err_ff <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      rx_err_ff <= 1'b0;
      rx_prev_ff <= rx_pin_i;
      if (wr_status & hwdata_i[`MMS_STA_PERR]) begin
        perr_ff <= 1'b0;
      end
      if (wr_status & hwdata_i[`MMS_STA_FERR]) begin
        ferr_ff <= 1'b0;
      end
      if (csi_sample) begin
        rx_sh_ff[bit_idx(lsb_first, len8, tx_cnt_ff)] <= rx_pin_i; // RULE_11
      end
      if (is_csi && rx_en && tx_st_ff == T_DONE) begin
        rx_buf_ff <= rx_masked; // RULE_16
        rx_done_ff <= 1'b1;
      end
      if (!(run && is_uart && rx_en)) begin
        rx_st_ff <= R_IDLE; // RULE_04
      end else begin
        case (rx_st_ff)
          R_IDLE: begin
            if (!sw_start && rx_prev_ff && !rx_pin_i) begin
              rx_st_ff <= R_START; // RULE_01 RULE_20
              rx_half_ff <= 1'b0;
              rx_cnt_ff <= 3'd0;
              perr_frame_ff <= 1'b0;
              ferr_frame_ff <= 1'b0;
            end
          end
          R_START: begin
            if (rx_tick) begin
              rx_st_ff <= rx_pin_i ? R_IDLE : R_DATA;
            end
          end
          R_DATA, R_PAR, R_STOP: begin
            if (rx_tick) begin
              rx_half_ff <= ~rx_half_ff;
            end
            if (rx_tick && rx_half_ff) begin
              case (rx_st_ff)
                R_DATA: begin
                  rx_sh_ff[bit_idx(lsb_first, len8, rx_cnt_ff)] <= rx_bit; // RULE_14
                  if (rx_cnt_ff != last_cnt) begin
                    rx_cnt_ff <= rx_cnt_ff + 3'd1;
                  end else if (ptc != `MMS_PTC_NONE) begin
                    rx_st_ff <= R_PAR; // RULE_09
                  end else begin
                    rx_st_ff <= stop_en ? R_STOP : R_DONE; // RULE_12
                  end
                end
                R_PAR: begin
                  perr_frame_ff <= par_bad; // RULE_23
                  rx_st_ff <= stop_en ? R_STOP : R_DONE;
                end
                default: begin
                  ferr_frame_ff <= ~rx_bit;
                  rx_st_ff <= R_DONE;
                end
              endcase
            end
          end
          R_DONE: begin
            rx_st_ff <= R_IDLE;
            rx_buf_ff <= rx_masked; // RULE_16
            if (perr_frame_ff) begin
              perr_ff <= 1'b1; // RULE_23
            end
            if (ferr_frame_ff) begin
              ferr_ff <= 1'b1;
            end
            if ((perr_frame_ff | ferr_frame_ff) & setup_ff[`MMS_SET_EOC]) begin
              rx_err_ff <= 1'b1; // RULE_06
            end else begin
              rx_done_ff <= 1'b1; // RULE_06
            end
          end
          default: rx_st_ff <= R_IDLE;
        endcase
      end
    end
  end
endmodule // mms_serial_channel

// ==== shared/mms_defs.vh ====
// Constants of the multi-mode serial channel
`ifndef MMS_DEFS_VH
`define MMS_DEFS_VH
// Register indices, byte address is four times the index
`define MMS_IDX_MODE 20'hF_0152
`define MMS_IDX_SETUP 20'hF_015A
`define MMS_IDX_START 20'hF_0162
`define MMS_IDX_STOP 20'hF_0164
`define MMS_IDX_DATA 20'hF_0170
`define MMS_IDX_STATUS 20'hF_0172
// Reset values
`define MMS_RST_MODE 16'h0020
`define MMS_RST_SETUP 16'h0087
// Writable bits and bits that read as one
`define MMS_WMASK_MODE 16'h8147
`define MMS_FIXED_MODE 16'h0020
`define MMS_WMASK_SETUP 16'hF791
`define MMS_FIXED_SETUP 16'h0006
// Mode register fields
`define MMS_MODE_OPCLK 15
`define MMS_MODE_STSRC 8
`define MMS_MODE_RXINV 6
`define MMS_MODE_MDHI 2
`define MMS_MODE_MDLO 1
`define MMS_MODE_IRQSRC 0
// Setup register fields
`define MMS_SET_TXEN 15
`define MMS_SET_RXEN 14
`define MMS_SET_DAP 13
`define MMS_SET_CKP 12
`define MMS_SET_EOC 10
`define MMS_SET_PTCHI 9
`define MMS_SET_PTCLO 8
`define MMS_SET_DIR 7
`define MMS_SET_SLC 4
`define MMS_SET_DLS 0
// Divider field of the data register
`define MMS_DIV_HI 15
`define MMS_DIV_LO 9
// Trigger bit of this channel in start and stop registers
`define MMS_TRIG_BIT 1
// Status fields
`define MMS_STA_ACTIVE 0
`define MMS_STA_TXPEND 1
`define MMS_STA_TXBUSY 2
`define MMS_STA_RXBUSY 3
`define MMS_STA_PERR 4
`define MMS_STA_FERR 5
// Channel modes
`define MMS_MD_CSI 2'b00
`define MMS_MD_UART 2'b01
`define MMS_MD_IIC 2'b10
// Parity settings
`define MMS_PTC_NONE 2'b00
`define MMS_PTC_ZERO 2'b01
`define MMS_PTC_EVEN 2'b10
`define MMS_PTC_ODD 2'b11
// Bus response
`define MMS_HRESP_OKAY 1'b0
`endif

// ==== design/mms_tclk_div.v ====
// Transfer clock divider giving half-bit enable pulses
`timescale 1ns/1ps
module mms_tclk_div (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Control
  input wire op_tick_i,
  input wire clr_i,
  input wire [6:0] div_i,
  // Half-bit enable
  output wire half_tick_o
);
  reg [6:0] cnt_ff;
  reg tick_ff;

  assign half_tick_o = tick_ff;

  // Half period is field plus one operation ticks
  always @(posedge clk_i) begin
    if (sys_rst_i || clr_i) begin
      cnt_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (op_tick_i) begin
        if (cnt_ff == div_i) begin // RULE_15
          cnt_ff <= 7'h00;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 7'h01;
        end
      end
    end
  end
endmodule // mms_tclk_div

// ==== dv/mms_serial_checker.sv ====
// Port assertions for the serial channel
`timescale 1ns/1ps
`include "mms_defs.vh"
module mms_serial_checker (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Bus
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  // Serial side
  input wire txd_o,
  input wire sck_o,
  input wire xfer_irq_o,
  input wire rx_done_irq_o,
  input wire rx_error_irq_o,
  input wire channel_active_o
);
  ////////////////////////////////////////
  // Shadow of bus writes
  wire take = hsel_i & htrans_i[1] & hready_i;
  reg rd_dp_ff;
  reg wr_dp_ff;
  reg [19:0] idx_ff;
  reg eoc_ff;
  reg ckp_ff;
  reg stsrc_ff;
  reg src_ff;
  wire wr_set = wr_dp_ff && idx_ff == `MMS_IDX_SETUP;
  wire wr_mode = wr_dp_ff && idx_ff == `MMS_IDX_MODE;
  wire st_hit = wr_dp_ff && idx_ff == `MMS_IDX_START && hwdata_i[`MMS_TRIG_BIT];
  wire sp_hit = wr_dp_ff && idx_ff == `MMS_IDX_STOP && hwdata_i[`MMS_TRIG_BIT];
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_dp_ff <= 1'b0;
      wr_dp_ff <= 1'b0;
      idx_ff <= 20'h0_0000;
      eoc_ff <= 1'b0;
      ckp_ff <= 1'b0;
      stsrc_ff <= 1'b0;
      src_ff <= 1'b0;
    end else begin
      rd_dp_ff <= take & !hwrite_i;
      wr_dp_ff <= take & hwrite_i;
      idx_ff <= haddr_i[21:2];
      if (wr_set) begin
        eoc_ff <= hwdata_i[`MMS_SET_EOC];
        ckp_ff <= hwdata_i[`MMS_SET_CKP];
      end
      if (wr_mode) begin
        stsrc_ff <= hwdata_i[`MMS_MODE_STSRC];
        src_ff <= hwdata_i[`MMS_MODE_IRQSRC];
      end
    end
  end
  ////////////////////////////////////////
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  bus_okay_a: assert property ($past(!sys_rst_i) |-> hreadyout_o && hresp_o == `MMS_HRESP_OKAY)
    else $error("bus not ready or not okay");
  rdata_idle_a: assert property (!rd_dp_ff |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside data phase");
  txd_idle_a: assert property ((!channel_active_o)[*3] |-> txd_o)
    else $error("serial data not idle when stopped");
  sck_idle_a: assert property ((!channel_active_o && $stable(ckp_ff))[*3] |-> sck_o == !ckp_ff)
    else $error("serial clock idle level wrong");
  act_rise_a: assert property ($rose(channel_active_o) |-> $past(st_hit))
    else $error("active flag set without start");
  act_fall_a: assert property ($fell(channel_active_o) |-> $past(sp_hit))
    else $error("active flag cleared without stop");
  err_mask_a: assert property (rx_error_irq_o |-> eoc_ff && !rx_done_irq_o)
    else $error("error event while masked");
  pulse_one_a: assert property (xfer_irq_o || rx_done_irq_o |=> !xfer_irq_o && !rx_done_irq_o)
    else $error("event longer than one cycle");
  tx_start_a: assert property ($fell(txd_o) |-> channel_active_o && !stsrc_ff)
    else $error("frame started without software trigger");
  src_empty_a: assert property (xfer_irq_o && src_ff |-> ##[0:3] !txd_o)
    else $error("buffer empty event not at load");
  src_end_a: assert property (xfer_irq_o && !src_ff |-> txd_o)
    else $error("transfer end event inside frame");
  // Main scenarios
  rx_done_c: cover property (rx_done_irq_o);
  rx_err_c: cover property (rx_error_irq_o);
  stop_c: cover property ($fell(channel_active_o));
  empty_c: cover property (xfer_irq_o && src_ff);
endmodule // mms_serial_checker

bind mms_serial_channel mms_serial_checker chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .txd_o(txd_o), .sck_o(sck_o),
  .xfer_irq_o(xfer_irq_o), .rx_done_irq_o(rx_done_irq_o), .rx_error_irq_o(rx_error_irq_o),
  .channel_active_o(channel_active_o));

// ==== dv/mms_serial_peer.sv ====
// Serial peer on the receive and transmit lines
`timescale 1ns/1ps
module mms_serial_peer (
  // Clock
  input wire clk_i,
  // Line and timing
  input wire txd_i,
  input wire [7:0] half_i,
  output logic rx_pin_o,
  output logic got_o,
  output logic [8:0] raw_o
);
  integer i;
  integer j;
  initial begin
    rx_pin_o = 1'b1;
    got_o = 1'b0;
    raw_o = 9'h000;
  end
  // Send start then n bits, first bit in b[0]
  task send(input [9:0] b, input integer n);
    begin
      rx_pin_o <= 1'b0;
      repeat (2 * half_i) @(posedge clk_i);
      for (i = 0; i < n; i = i + 1) begin
        rx_pin_o <= b[i];
        repeat (2 * half_i) @(posedge clk_i);
      end
      rx_pin_o <= 1'b1;
    end
  endtask
  // Capture nine bits after each start bit
  always begin
    @(negedge txd_i);
    // Start bit may run one clock long, so aim past its middle
    repeat (half_i + 1) @(negedge clk_i);
    for (j = 0; j < 9; j = j + 1) begin
      repeat (2 * half_i) @(negedge clk_i);
      raw_o[j] = txd_i;
    end
    @(posedge clk_i);
    got_o <= 1'b1;
    @(posedge clk_i);
    got_o <= 1'b0;
  end
endmodule // mms_serial_peer

// ==== dv/tb_top.sv ====
// Self-checking bench for the serial channel
`timescale 1ns/1ps
`include "mms_defs.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic prs1_tick_i = 1'b0;
  logic [7:0] half = 8'h02;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, rx_pin_i, txd_o, sck_o, got;
  wire xfer_irq_o, rx_done_irq_o, rx_error_irq_o, channel_active_o;
  wire [8:0] raw;
  integer bad_count = 0;
  integer checks = 0;
  integer k;
  integer c;
  logic [31:0] seed = 32'h0000_989e;
  logic [31:0] rd_q[$], tx_q[$], ev_q[$];
  logic rd_dp = 1'b0;
  logic seen = 1'b0;
  logic [7:0] d;
  logic p;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) prs1_tick_i <= ~prs1_tick_i;
  mms_serial_channel uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .prs0_tick_i(1'b1),
    .prs1_tick_i(prs1_tick_i), .rx_pin_i(rx_pin_i), .txd_o(txd_o), .sck_o(sck_o), .xfer_irq_o(xfer_irq_o),
    .rx_done_irq_o(rx_done_irq_o), .rx_error_irq_o(rx_error_irq_o), .channel_active_o(channel_active_o));
  mms_serial_peer peer (.clk_i(clk_i), .txd_i(txd_o), .half_i(half), .rx_pin_o(rx_pin_i), .got_o(got),
    .raw_o(raw));
  ////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Line bits after the start bit for one frame
  function [31:0] txexp(input [7:0] v, input [3:0] m);
    reg [8:0] s;
    integer j;
    integer nb;
    begin
      nb = m[3] ? 8 : 7;
      s = 9'h1ff;
      for (j = 0; j < nb; j = j + 1) s[j] = m[2] ? v[j] : v[nb - 1 - j];
      if (m[1:0] != 2'b00) s[nb] = m[1] & (m[0] ^ ^(v & {m[3], 7'h7f}));
      txexp = {23'h00_0000, s};
    end
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string s, input logic [31:0] got_v, input logic [31:0] exp_v);
    begin
      checks = checks + 1;
      if (got_v !== exp_v) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", s, exp_v, got_v);
      end
    end
  endtask
  task rdy;
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1 && n < 64) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n == 64) bad_count = bad_count + 1;
      if (n == 64) close_out;
    end
  endtask
  task bus(input w, input [19:0] i, input [15:0] v);
    begin
      if (!w) rd_q.push_back({16'h0000, v});
      hsel_i <= 1'b1;
      haddr_i <= {10'h000, i, 2'b00};
      htrans_i <= 2'b10;
      hwrite_i <= w;
      rdy;
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= {16'h0000, v};
      rdy;
    end
  endtask
  task wt;
    integer n;
    begin
      n = 0;
      while (!seen && n < 3000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (!seen) bad_count = bad_count + 1;
      if (!seen) close_out;
      else seen = 1'b0;
    end
  endtask
  ////////////////////////////////////////
  // Result watcher
  always @(negedge clk_i) begin
    if (rd_dp) chk("hrdata", hrdata_o, rd_q.pop_front());
    if (got === 1'b1) chk("frame", {23'h00_0000, raw}, tx_q.pop_front());
    if ((rx_done_irq_o | rx_error_irq_o) === 1'b1)
      chk("rx event", {30'h0000_0000, rx_error_irq_o, rx_done_irq_o}, ev_q.pop_front());
    if ((got | rx_done_irq_o | rx_error_irq_o) === 1'b1) seen = 1'b1;
    rd_dp = hsel_i & htrans_i[1] & !hwrite_i & hreadyout_o;
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, `MMS_IDX_MODE, 16'h0020);
    bus(0, `MMS_IDX_SETUP, 16'h0087);
    bus(1, 20'hF_0100, 16'hFFFF);
    bus(0, 20'hF_0100, 16'h0000);
    bus(1, `MMS_IDX_SETUP, 16'hFFFF);
    bus(0, `MMS_IDX_SETUP, 16'hF797);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1, `MMS_IDX_SETUP, {2'b10, k[1:0], 12'h000});
      repeat (4) @(posedge clk_i);
    end
    bus(1, `MMS_IDX_START, 16'h0002);
    bus(0, `MMS_IDX_STATUS, 16'h0001);
    // Clocked transfer, all ones out, idle line shifted in
    bus(1, `MMS_IDX_SETUP, 16'hC081);
    ev_q.push_back(32'h0000_0001);
    bus(1, `MMS_IDX_DATA, 16'h00FF);
    wt;
    bus(0, `MMS_IDX_DATA, 16'h00FF);
    for (k = 0; k < 16; k = k + 1) begin
      seed = lfsr(seed);
      half <= ({6'h00, seed[9:8]} + 8'h01) << seed[10];
      bus(1, `MMS_IDX_MODE, {seed[10], 14'h0000, k[0]} | 16'h0002);
      bus(1, `MMS_IDX_SETUP, {6'h20, k[1:0], k[2], 2'b00, 1'b1, 3'b000, k[3]});
      tx_q.push_back(txexp(seed[7:0], k[3:0]));
      bus(1, `MMS_IDX_DATA, {5'h00, seed[9:8], 1'b0, seed[7:0]});
      wt;
      repeat (64) @(posedge clk_i);
    end
    half <= 8'h02;
    bus(1, `MMS_IDX_MODE, 16'h0102);
    bus(1, `MMS_IDX_DATA, 16'h0200);
    for (c = 0; c < 4; c = c + 1) begin
      seed = lfsr(seed);
      d = seed[7:0];
      p = (c == 1) ? ~^d : ^d;
      bus(1, `MMS_IDX_MODE, (c == 3) ? 16'h0142 : 16'h0102);
      bus(1, `MMS_IDX_SETUP, (c == 3) ? 16'h4080 : {4'h4, 1'b0, c < 2, c == 2 ? 2'b11 : 2'b10, 8'h91});
      ev_q.push_back(c == 1 ? 32'h0000_0002 : 32'h0000_0001);
      if (c == 3) peer.send({3'b000, ~d[6:0]}, 7);
      else peer.send({1'b1, p, d}, 10);
      wt;
      if (c != 1) bus(0, `MMS_IDX_DATA, {8'h02, c == 3 ? {1'b0, d[6:0]} : d});
    end
    bus(1, `MMS_IDX_STATUS, 16'h0030);
    bus(1, `MMS_IDX_STOP, 16'h0000);
    bus(0, `MMS_IDX_STATUS, 16'h0003);
    bus(1, `MMS_IDX_STOP, 16'h0002);
    bus(0, `MMS_IDX_STOP, 16'h0000);
    bus(0, `MMS_IDX_STATUS, 16'h0002);
    repeat (8) @(posedge clk_i);
    close_out;
  end
endmodule // tb_top
